// >>> ctm_ext_src.sv
// External count source model: bursts of clean pulses, idle low
`timescale 1ns/100ps
module ctm_ext_src (
  input  wire logic       mclk,     // System clock
  input  wire logic       go,       // Start a burst
  input  wire logic [7:0] num,      // Pulses in the burst, nonzero
  output logic            ext_out,  // Drives the external count input
  output logic            busy      // Burst in progress
);
  logic [7:0] left_reg;
  logic [2:0] ph_reg;

  initial begin
    ext_out  = 1'b0;
    busy     = 1'b0;
    left_reg = 8'h00;
    ph_reg   = 3'h0;
  end

  // Three cycles high, three low, so a two-flop sync sees every edge
  always @(posedge mclk) begin
    if (go && !busy) begin
      busy     <= 1'b1;
      left_reg <= num;
      ph_reg   <= 3'h0;
    end else if (busy) begin
      ph_reg  <= (ph_reg == 3'h5) ? 3'h0 : ph_reg + 3'h1;
      ext_out <= (ph_reg < 3'h3);
      if (ph_reg == 3'h5) begin
        left_reg <= left_reg - 8'h01;
        if (left_reg == 8'h01) begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule  // ctm_ext_src

// >>> ctm_pkg.sv
// Package for the compact timer: register map, fields, modes, clock codes
package ctm_pkg;

  // ------------------------------------------------------------------------
  // Register indices (chosen offsets)
  // ------------------------------------------------------------------------
  localparam logic [2:0] CTM_ADDR_CTRL0   = 3'h0;
  localparam logic [2:0] CTM_ADDR_CTRL1   = 3'h1;
  localparam logic [2:0] CTM_ADDR_CNT_LO  = 3'h2;
  localparam logic [2:0] CTM_ADDR_CNT_HI  = 3'h3;
  localparam logic [2:0] CTM_ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] CTM_ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] CTM_ADDR_CMPP    = 3'h6;

  // ------------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------------
  localparam int CTM_C0_PAUSE  = 7;
  localparam int CTM_C0_CKS_HI = 6;
  localparam int CTM_C0_CKS_LO = 4;
  localparam int CTM_C0_ON     = 3;
  localparam int CTM_C1_MODE_HI = 7;
  localparam int CTM_C1_MODE_LO = 6;
  localparam int CTM_C1_IO_HI  = 5;
  localparam int CTM_C1_IO_LO  = 4;
  localparam int CTM_C1_OC     = 3;
  localparam int CTM_C1_POL    = 2;
  localparam int CTM_C1_DPX    = 1;
  localparam int CTM_C1_CCLR   = 0;

  localparam logic [7:0] CTM_C0_MASK  = 8'hF8;
  localparam logic [7:0] CTM_RST_BYTE = 8'h00;
  localparam logic [15:0] CTM_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CTM_CNT_ONE = 16'h0001;

  // ------------------------------------------------------------------------
  // Modes, pin actions, clock selections
  // ------------------------------------------------------------------------
  localparam logic [1:0] CTM_MODE_CMP = 2'h0;
  localparam logic [1:0] CTM_MODE_PWM = 2'h2;
  localparam logic [1:0] CTM_MODE_TMR = 2'h3;

  localparam logic [1:0] CTM_IO_NONE = 2'h0;
  localparam logic [1:0] CTM_IO_LOW  = 2'h1;
  localparam logic [1:0] CTM_IO_HIGH = 2'h2;
  localparam logic [1:0] CTM_IO_TOG  = 2'h3;

  localparam logic [2:0] CTM_CK_SYS4  = 3'h0;
  localparam logic [2:0] CTM_CK_SYS   = 3'h1;
  localparam logic [2:0] CTM_CK_H16   = 3'h2;
  localparam logic [2:0] CTM_CK_H64   = 3'h3;
  localparam logic [2:0] CTM_CK_TBC   = 3'h4;
  localparam logic [2:0] CTM_CK_H8    = 3'h5;
  localparam logic [2:0] CTM_CK_EXT_R = 3'h6;
  localparam logic [2:0] CTM_CK_EXT_F = 3'h7;

  // Prescaler taps: bit i of the divider rises every 2**(i+1) cycles
  localparam int CTM_DIV_W    = 6;
  localparam int CTM_TAP_SYS4 = 1;
  localparam int CTM_TAP_H8   = 2;
  localparam int CTM_TAP_H16  = 3;
  localparam int CTM_TAP_H64  = 5;

endpackage

// >>> ctm_timer.sv
// Compact 16-bit timer: counter, two comparators, output pin, registers
//
// Functional notes
// [R1] 16-bit counter counts up on clock edges
// [R2] Compare P matches counter upper byte only
// [R3] Compare A matches all sixteen counter bits
// [R4] Software only clears counter via run-on rise
// [R5] Overflow or selected match clears, raises request; no flag is raised on overflow
// [R6] Pause holds count, resumes from held value
// [R7] Clock select picks one of eight sources
// [R8] Run-on low stops counting, keeps residual value
// [R9] Run-on rising edge zeroes the counter
// [R10] Run-on rise loads initial pin level
// [R11] Mode bits: compare, undefined, PWM, timer
// [R12] Software switches off before mode changes
// [R13] Software disables pin use in timer mode
// [R14] Compare mode A match: none/low/high/toggle
// [R15] PWM pin action: inactive, active, waveform
// [R16] Match to same level shows no change
// [R17] Software changes PWM pin action only off
// [R18] Initial level sets start or active level
// [R19] Invert bit inverts pin except timer mode
// [R20] Role bit swaps period and duty comparators
// [R21] Counter read-only pair, compare registers writable
// [R22] Control 0 low three bits read zero
// [R23] Clear select: A match, else P/overflow
// [R24] Compare P zero gives no period match
// [R25] Only A match moves pin in compare mode
// [R26] Low bytes pass through eight-bit holding buffer
// [R27] Counter wraps from all ones to zero
`timescale 1ns/100ps
module ctm_timer
  import ctm_pkg::*;
(
  input  wire logic       mclk,         // System clock, 50 MHz
  input  wire logic       sys_rst,      // Synchronous reset, active high
  input  wire logic [2:0] reg_addr,     // Register index
  input  wire logic [7:0] reg_wdata,    // Write data
  input  wire logic       reg_wr,       // Write strobe
  input  wire logic       reg_rd,       // Read strobe
  output logic      [7:0] reg_rdata,    // Read data, cycle after strobe
  input  wire logic       high_clk_tick,  // High internal clock tick
  input  wire logic       time_base_clock, // Time-base clock level
  input  wire logic       external_count_input, // External count pin
  output logic            timer_output_pin, // Timer output pin
  output logic            match_a_flag,     // Comparator A match pulse
  output logic            match_p_flag      // Comparator P match pulse, not raised when A match clears
);

  // ------------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------------
  logic [7:0]  ctrl0_reg;
  logic [7:0]  ctrl1_reg;
  logic [15:0] count_reg;
  logic [15:0] cmpa_reg;
  logic [7:0]  cmpp_reg;
  logic [7:0]  hold_reg;
  logic        on_d_reg;
  logic        pin_reg;
  logic [CTM_DIV_W-1:0] sdiv_reg;
  logic [CTM_DIV_W-1:0] hdiv_reg;
  logic [2:0]  ext_sync_reg;
  logic [2:0]  tbc_sync_reg;

  logic        run_on;
  logic        count_pause;
  logic [2:0]  count_clock_select;
  logic [1:0]  operating_mode_select;
  logic [1:0]  pin_action_select;
  logic        output_initial_level;
  logic        output_invert;
  logic        pwm_role_swap;
  logic        clear_select;

  assign run_on                = ctrl0_reg[CTM_C0_ON];
  assign count_pause           = ctrl0_reg[CTM_C0_PAUSE];
  assign count_clock_select    = ctrl0_reg[CTM_C0_CKS_HI:CTM_C0_CKS_LO];
  assign operating_mode_select = ctrl1_reg[CTM_C1_MODE_HI:CTM_C1_MODE_LO];
  assign pin_action_select     = ctrl1_reg[CTM_C1_IO_HI:CTM_C1_IO_LO];
  assign output_initial_level  = ctrl1_reg[CTM_C1_OC];
  assign output_invert         = ctrl1_reg[CTM_C1_POL];
  assign pwm_role_swap         = ctrl1_reg[CTM_C1_DPX];
  assign clear_select          = ctrl1_reg[CTM_C1_CCLR];

  logic wr_c0;
  logic on_rise;
  assign wr_c0   = reg_wr && (reg_addr == CTM_ADDR_CTRL0);
  assign on_rise = run_on && !on_d_reg;

  // ------------------------------------------------------------------------
  // Clock sources
  // ------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sdiv_reg <= '0;
      hdiv_reg <= '0;
    end else begin
      sdiv_reg <= sdiv_reg + 1'b1;
      if (high_clk_tick) begin
        hdiv_reg <= hdiv_reg + 1'b1;
      end
    end
  end

  // Pins pass two flops; the third stage is for edge detection
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ext_sync_reg <= '0;
      tbc_sync_reg <= '0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], external_count_input};
      tbc_sync_reg <= {tbc_sync_reg[1:0], time_base_clock};
    end
  end

  // Tick on the cycle a divider tap rises
  function automatic logic tap_rise(input logic [CTM_DIV_W-1:0] cur,
                                    input int tap);
    logic [CTM_DIV_W-1:0] nxt;
    nxt = cur + 1'b1;
    return !cur[tap] && nxt[tap];
  endfunction

  logic cnt_tick;
  always_comb begin
    case (count_clock_select)                                       // R7
      CTM_CK_SYS4:  cnt_tick = tap_rise(sdiv_reg, CTM_TAP_SYS4);
      CTM_CK_SYS:   cnt_tick = 1'b1;
      CTM_CK_H16:   cnt_tick = high_clk_tick &&
                               tap_rise(hdiv_reg, CTM_TAP_H16);
      CTM_CK_H64:   cnt_tick = high_clk_tick &&
                               tap_rise(hdiv_reg, CTM_TAP_H64);
      CTM_CK_TBC:   cnt_tick = tbc_sync_reg[1] && !tbc_sync_reg[2];
      CTM_CK_H8:    cnt_tick = high_clk_tick &&
                               tap_rise(hdiv_reg, CTM_TAP_H8);
      CTM_CK_EXT_R: cnt_tick = ext_sync_reg[1] && !ext_sync_reg[2];
      CTM_CK_EXT_F: cnt_tick = !ext_sync_reg[1] && ext_sync_reg[2];
      default:      cnt_tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------------
  // Comparators and counter
  // ------------------------------------------------------------------------
  logic adv;
  logic match_a;
  logic match_p;
  logic ovf;
  logic clr;
  assign adv     = run_on && !on_rise && !count_pause && cnt_tick; // R6 R8
  assign match_a = adv && (count_reg + CTM_CNT_ONE == cmpa_reg);   // R3
  assign match_p = adv && (cmpp_reg != CTM_RST_BYTE) &&            // R24
                   (count_reg + CTM_CNT_ONE == {cmpp_reg, CTM_RST_BYTE}); // R2
  assign ovf     = adv && (count_reg == CTM_CNT_MAX);              // R27
  assign clr     = clear_select ? match_a : (match_p || ovf);      // R23

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      on_d_reg <= 1'b0;
    end else begin
      on_d_reg <= run_on;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (on_rise) begin
      count_reg <= '0;                                              // R4 R9
    end else if (clr) begin
      count_reg <= '0;                                              // R5
    end else if (adv) begin
      count_reg <= count_reg + CTM_CNT_ONE;                         // R1 R27
    end
  end

  // Request flags as pulses; P is suppressed when A clears
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= match_a;                                      // R5
      match_p_flag <= match_p && !clear_select;                     // R5
    end
  end

  // ------------------------------------------------------------------------
  // Output pin
  // ------------------------------------------------------------------------
  logic [15:0] period_val;
  logic [15:0] duty_val;
  logic        pwm_active;
  assign period_val = pwm_role_swap ? cmpa_reg                     // R20
                                    : {cmpp_reg, CTM_RST_BYTE};
  assign duty_val   = pwm_role_swap ? {cmpp_reg, CTM_RST_BYTE} : cmpa_reg;
  assign pwm_active = (count_reg < duty_val) &&
                      ((period_val == '0) || (count_reg < period_val));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_reg <= 1'b0;
    end else if (operating_mode_select == CTM_MODE_CMP) begin       // R11
      if (on_rise) begin
        pin_reg <= output_initial_level;                            // R10 R18
      end else if (match_a) begin                                   // R25
        case (pin_action_select)                                    // R14 R16
          CTM_IO_LOW:  pin_reg <= 1'b0;
          CTM_IO_HIGH: pin_reg <= 1'b1;
          CTM_IO_TOG:  pin_reg <= !pin_reg;
          default:     pin_reg <= pin_reg;
        endcase
      end
    end else if (operating_mode_select == CTM_MODE_PWM) begin
      case (pin_action_select)                                      // R15
        CTM_IO_NONE: pin_reg <= !output_initial_level;              // R18
        CTM_IO_LOW:  pin_reg <= output_initial_level;
        CTM_IO_HIGH: pin_reg <= run_on && pwm_active ?
                                output_initial_level :
                                !output_initial_level;
        default:     pin_reg <= pin_reg;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_output_pin <= 1'b0;
    end else if (operating_mode_select == CTM_MODE_TMR) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= pin_reg ^ output_invert;                  // R19
    end
  end

  // ------------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl0_reg <= CTM_RST_BYTE;
      ctrl1_reg <= CTM_RST_BYTE;
      cmpa_reg  <= '0;
      cmpp_reg  <= CTM_RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        CTM_ADDR_CTRL0:   ctrl0_reg <= reg_wdata & CTM_C0_MASK;     // R22
        CTM_ADDR_CTRL1:   ctrl1_reg <= reg_wdata;
        CTM_ADDR_CMPA_HI: cmpa_reg  <= {reg_wdata, hold_reg};       // R26
        CTM_ADDR_CMPP:    cmpp_reg  <= reg_wdata;                   // R21
        default:          ;
      endcase
    end
  end

  // Shared low-byte buffer: filled by low writes and high reads
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_reg <= CTM_RST_BYTE;
    end else if (reg_wr && reg_addr == CTM_ADDR_CMPA_LO) begin
      hold_reg <= reg_wdata;                                        // R26
    end else if (reg_rd && reg_addr == CTM_ADDR_CNT_HI) begin
      hold_reg <= count_reg[7:0];                                   // R26
    end else if (reg_rd && reg_addr == CTM_ADDR_CMPA_HI) begin
      hold_reg <= cmpa_reg[7:0];                                    // R26
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= CTM_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        CTM_ADDR_CTRL0:   reg_rdata <= ctrl0_reg & CTM_C0_MASK;     // R22
        CTM_ADDR_CTRL1:   reg_rdata <= ctrl1_reg;
        CTM_ADDR_CNT_LO:  reg_rdata <= hold_reg;                    // R26
        CTM_ADDR_CNT_HI:  reg_rdata <= count_reg[15:8];             // R21
        CTM_ADDR_CMPA_LO: reg_rdata <= hold_reg;
        CTM_ADDR_CMPA_HI: reg_rdata <= cmpa_reg[15:8];
        CTM_ADDR_CMPP:    reg_rdata <= cmpp_reg;
        default:          reg_rdata <= CTM_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= CTM_RST_BYTE;
    end
  end

  // ------------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------------
  sequence s_on_rise;
    !on_d_reg && run_on;
  endsequence

  property p_zero_on_start;
    @(posedge mclk) disable iff (sys_rst) s_on_rise |=> count_reg == '0;
  endproperty
  a_zero_on_start: assert property (p_zero_on_start)                // R9
    else $error("Counter not zero after run-on rise");

  property p_off_holds;
    @(posedge mclk) disable iff (sys_rst)
      (!run_on && !on_d_reg) |=> $stable(count_reg);
  endproperty
  a_off_holds: assert property (p_off_holds)                        // R8
    else $error("Counter moved while off");

  property p_pause_holds;
    @(posedge mclk) disable iff (sys_rst)
      (count_pause && on_d_reg && $past(count_pause)) |=> $stable(count_reg);
  endproperty
  a_pause_holds: assert property (p_pause_holds)                    // R6
    else $error("Counter moved while paused");

  property p_count_up;
    @(posedge mclk) disable iff (sys_rst)
      (adv && !clr && !on_rise) |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up)                          // R1
    else $error("Counter did not advance by one");

  property p_p_zero;
    @(posedge mclk) disable iff (sys_rst)
      cmpp_reg == CTM_RST_BYTE |-> !match_p;
  endproperty
  a_p_zero: assert property (p_p_zero)                              // R24
    else $error("Period match with zero compare P");

  property p_clear_a;
    @(posedge mclk) disable iff (sys_rst)
      (clear_select && match_a && !on_rise) |=> count_reg == '0 ##0
        match_a_flag && !match_p_flag;
  endproperty
  a_clear_a: assert property (p_clear_a)                            // R23
    else $error("A match did not clear counter");

  property p_c0_low_zero;
    @(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_addr == CTM_ADDR_CTRL0) |=> reg_rdata[2:0] == 3'h0;
  endproperty
  a_c0_low_zero: assert property (p_c0_low_zero)                    // R22
    else $error("Control 0 low bits read nonzero");

  property p_init_level;
    @(posedge mclk) disable iff (sys_rst)
      (s_on_rise ##0 operating_mode_select == CTM_MODE_CMP) |=>
        pin_reg == $past(output_initial_level);
  endproperty
  a_init_level: assert property (p_init_level)                      // R10
    else $error("Pin not at initial level after start");

  property p_invert;
    @(posedge mclk) disable iff (sys_rst)
      operating_mode_select != CTM_MODE_TMR |=>
        timer_output_pin == ($past(pin_reg) ^ $past(output_invert));
  endproperty
  a_invert: assert property (p_invert)                              // R19
    else $error("Output polarity wrong");

endmodule // ctm_timer

// >>> tb.sv
// Self-checking bench for the compact timer
`timescale 1ns/100ps
module tb;
  import ctm_pkg::*;
  logic        mclk, sys_rst, reg_wr, reg_rd, hclk, tbclk;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, src_n, rv;
  logic        src_go, src_busy, ext_in, pin, fa, fp;
  logic [15:0] cv, pv, e;
  int          failures, total_checks, na, np, tbc;
  logic [15:0] pw_exp [4] = '{16'd0, 16'd1024, 16'd256, 16'd512};
  logic [2:0]  ck_sel [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
  int          ck_div [5] = '{4, 32, 128, 20, 16};

  ctm_timer DUT (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .high_clk_tick(hclk), .time_base_clock(tbclk),
    .external_count_input(ext_in), .timer_output_pin(pin),
    .match_a_flag(fa), .match_p_flag(fp));
  ctm_ext_src SRC (.mclk(mclk), .go(src_go), .num(src_n),
    .ext_out(ext_in), .busy(src_busy));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // High clock ticks every 2 cycles, time base rises every 20
  always @(posedge mclk) begin
    hclk <= ~hclk;
    tbc  <= (tbc == 9) ? 0 : tbc + 1;
    if (tbc == 9) tbclk <= ~tbclk;
  end
  // Flags counted mid-cycle, away from the bench's edge activity
  always @(negedge mclk) begin
    if (fa === 1'b1) na++;
    if (fp === 1'b1) np++;
  end

  // --------------------------------------------------------------
  // Bus and helper tasks
  // --------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
    wr(lo, v[7:0]);
    wr(lo + 3'h1, v[15:8]);
  endtask
  task automatic rd16(input logic [2:0] hi, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(hi, h);
    rd(hi - 3'h1, l);
    v = {h, l};
  endtask
  // Module is switched off before mode or pin action changes
  task automatic run(input logic [7:0] c1, input logic [7:0] c0);
    wr(CTM_ADDR_CTRL0, 8'h00);
    wr(CTM_ADDR_CTRL1, c1);
    wr(CTM_ADDR_CTRL0, c0);
  endtask
  task automatic pulses(input logic [7:0] n);
    int k;
    @(posedge mclk);
    src_n  <= n;
    src_go <= 1'b1;
    @(posedge mclk);
    src_go <= 1'b0;
    k = 0;
    #1;
    while (src_busy === 1'b1 && k < 4000) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k < 4000) begin
      cyc(4);
    end else begin
      failures++;
      wrap_up();
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    rd(CTM_ADDR_CTRL0, rv);
    chk({8'h00, rv}, 16'h0000);
    rd(CTM_ADDR_CTRL1, rv);
    chk({8'h00, rv}, 16'h0000);
    rd(3'h7, rv);
    chk({8'h00, rv}, 16'h0000);
    wr(CTM_ADDR_CTRL0, 8'hFF);
    rd(CTM_ADDR_CTRL0, rv);
    chk({8'h00, rv}, 16'h00F8);
    wr(CTM_ADDR_CTRL0, 8'h00);
    wr16(CTM_ADDR_CNT_LO, 16'hABCD);
    rd16(CTM_ADDR_CNT_HI, cv);
    chk(cv, 16'h0000);
    wr16(CTM_ADDR_CMPA_LO, 16'h1234);
    wr(CTM_ADDR_CMPA_LO, 8'h77);
    rd16(CTM_ADDR_CMPA_HI, cv);
    chk(cv, 16'h1234);
    wr(CTM_ADDR_CMPP, 8'h5A);
    rd(CTM_ADDR_CMPP, rv);
    chk({8'h00, rv}, 16'h005A);
  endtask
  task automatic t_pause();
    run(8'hC0, 8'h18);
    cyc(50);
    wr(CTM_ADDR_CTRL0, 8'h98);
    rd16(CTM_ADDR_CNT_HI, cv);
    cyc(20);
    rd16(CTM_ADDR_CNT_HI, pv);
    chk(pv, cv);
    chk({15'h0, cv > 16'd40}, 16'h0001);
    wr(CTM_ADDR_CTRL0, 8'h18);
    cyc(20);
    rd16(CTM_ADDR_CNT_HI, pv);
    chk({15'h0, pv > cv + 16'd15}, 16'h0001);
  endtask
  task automatic t_pin();
    logic [1:0] io;
    logic       oc, pol, e1, e2;
    wr16(CTM_ADDR_CMPA_LO, 16'h0005);
    wr(CTM_ADDR_CMPP, 8'h00);
    for (int k = 0; k < 16; k++) begin
      io  = 2'(k);
      oc  = k[2];
      pol = k[3];
      e1  = (io == 2'h0) ? oc : (io == 2'h3) ? ~oc : io[1];
      e2  = (io == 2'h3) ? oc : e1;
      run({2'b00, io, oc, pol, 2'b01}, 8'h68);
      cyc(2);
      #1;
      chk({15'h0, pin}, {15'h0, oc ^ pol});
      na = 0;
      np = 0;
      pulses(8'd5);
      chk({15'h0, pin}, {15'h0, e1 ^ pol});
      pulses(8'd5);
      chk({15'h0, pin}, {15'h0, e2 ^ pol});
      chk(16'(na), 16'd2);
      chk(16'(np), 16'd0);
    end
  endtask
  task automatic t_count();
    for (int s = 6; s < 8; s++) begin
      run(8'hCC, {1'b0, 3'(s), 4'h8});
      cyc(2);
      #1;
      chk({15'h0, pin}, 16'h0000);
      pulses(8'd10);
      wr(CTM_ADDR_CTRL0, {1'b0, 3'(s), 4'h0});
      pulses(8'd3);
      rd16(CTM_ADDR_CNT_HI, cv);
      chk(cv, 16'd10);
      wr(CTM_ADDR_CTRL0, {1'b0, 3'(s), 4'h8});
      cyc(3);
      rd16(CTM_ADDR_CNT_HI, cv);
      chk(cv, 16'd0);
    end
  endtask
  task automatic t_period();
    wr16(CTM_ADDR_CMPA_LO, 16'h0110);
    wr(CTM_ADDR_CMPP, 8'h02);
    run(8'h30, 8'h18);
    na = 0;
    np = 0;
    cyc(900);
    chk(16'(np), 16'd1);
    chk(16'(na), 16'd2);
    chk({15'h0, pin}, 16'h0000);
    wr(CTM_ADDR_CMPP, 8'h01);
    run(8'h31, 8'h18);
    na = 0;
    np = 0;
    cyc(1000);
    chk(16'(np), 16'd0);
    chk(16'(na), 16'd3);
    wr(CTM_ADDR_CMPP, 8'h00);
    run(8'h30, 8'h18);
    na = 0;
    np = 0;
    cyc(65600);
    chk(16'(np), 16'd0);
    chk(16'(na), 16'd1);
    rd16(CTM_ADDR_CNT_HI, cv);
    chk({15'h0, cv < 16'h0100}, 16'h0001);
  endtask
  task automatic t_pwm();
    int hi;
    wr16(CTM_ADDR_CMPA_LO, 16'h0040);
    wr(CTM_ADDR_CMPP, 8'h01);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) wr16(CTM_ADDR_CMPA_LO, 16'h0200);
      run((k == 3) ? 8'hAB : {2'b10, 2'(k), 4'h8}, 8'h18);
      cyc(600);
      hi = 0;
      repeat (1024) begin
        @(posedge mclk);
        #1;
        if (pin === 1'b1) hi++;
      end
      chk(16'(hi), pw_exp[k]);
    end
  endtask
  task automatic t_clk();
    wr(CTM_ADDR_CMPP, 8'h00);
    for (int k = 0; k < 5; k++) begin
      run(8'hC0, {1'b0, ck_sel[k], 4'h8});
      cyc(1280);
      wr(CTM_ADDR_CTRL0, {1'b0, ck_sel[k], 4'h0});
      rd16(CTM_ADDR_CNT_HI, cv);
      e = 16'(1280 / ck_div[k]);
      chk({15'h0, cv + 16'd2 >= e && cv <= e + 16'd2}, 16'h0001);
    end
  endtask

  initial begin
    sys_rst      = 1'b1;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_addr     = 3'h0;
    reg_wdata    = 8'h00;
    hclk         = 1'b0;
    tbclk        = 1'b0;
    tbc          = 0;
    src_go       = 1'b0;
    src_n        = 8'h00;
    failures     = 0;
    total_checks = 0;
    na           = 0;
    np           = 0;
    cyc(4);
    sys_rst <= 1'b0;
    t_regs();
    t_pause();
    t_pin();
    t_count();
    t_period();
    t_pwm();
    t_clk();
    wrap_up();
  end
  initial begin
    #2000000;
    failures++;
    wrap_up();
  end
endmodule  // tb
